/* File: src/flash_cfg_pkg.sv */
// Package with the register map, config block layout and state types of the flash config loader
package flash_cfg_pkg;
  localparam int DATA_W = 32;
  localparam int FLASH_AW = 19;
  // Register byte offsets, decoded on paddr[7:0]
  localparam logic [7:0] OFS_BASE = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_PROT_PD = 8'h08;
  localparam logic [7:0] OFS_PROT_PE = 8'h0C;
  localparam logic [7:0] OFS_PROT_SU = 8'h10;
  localparam logic [7:0] OFS_KEY_HI = 8'h14;
  localparam logic [7:0] OFS_KEY_LO = 8'h18;
  localparam logic [7:0] OFS_SECURITY = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam int DEC_HI = 7;
  // Base register fields: bits 31:19 hold the 512-Kbyte aligned base, bit 0 marks it valid
  localparam int BASE_LSB = 19;
  localparam int BASE_W = 13;
  localparam int BASE_VALID_BIT = 0;
  localparam int CFG_LOCK_BIT = 0;
  localparam int STATUS_DONE_BIT = 0;
  localparam logic [BASE_W-1:0] BASE_BOOT = 13'h0000;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  // Nonvolatile configuration block: six words from byte 0x0400, 24 bytes
  localparam logic [FLASH_AW-1:0] CFG_START = 19'h00400;
  localparam logic [2:0] CFG_WORDS = 3'h6;
  localparam logic [2:0] IDX_KEY_HI = 3'h0;
  localparam logic [2:0] IDX_KEY_LO = 3'h1;
  localparam logic [2:0] IDX_PROT_PD = 3'h2;
  localparam logic [2:0] IDX_PROT_PE = 3'h3;
  localparam logic [2:0] IDX_PROT_SU = 3'h4;
  localparam logic [2:0] IDX_SECURITY = 3'h5;
  localparam int WORD_SHIFT = 2;

  typedef enum logic [1:0] {LD_STRAP, LD_REQ, LD_WAIT, LD_DONE} loader_state_type;

  typedef struct packed {
    logic valid;
    logic [FLASH_AW-1:0] addr;
  } flash_rd_req_type;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } flash_rd_rsp_type;

  typedef struct packed {
    loader_state_type ld;
    logic [2:0] idx;
    logic boot;
    logic [BASE_W-1:0] base;
    logic base_valid;
    logic lock;
    logic [DATA_W-1:0] key_hi;
    logic [DATA_W-1:0] key_lo;
    logic [DATA_W-1:0] prot_pd;
    logic [DATA_W-1:0] prot_pe;
    logic [DATA_W-1:0] prot_su;
    logic [DATA_W-1:0] security;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } state_type;
endpackage

/* File: src/flash_protection_config_loader.sv */
// Flash base register, reset-time config loader and protection registers behind APB
// Functional notes
// - Flash answers at the programmed base; software sets it unless booting from flash.
// - Booting from internal flash sets the base register to zero at reset.
// - Config block is read from flash byte 0x0400, spanning 24 bytes.
// - Every reset copies stored config into same-width registers with no software help.
// - Block holds key, program/data, program/erase, supervisor/user values, security word.
// - Each protection value is 32 bits, one bit per 16-Kbyte sector.
// - Protection registers always readable; writable only while the lock bit is zero.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module flash_protection_config_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_from_flash,
  input wire logic [31:0] cpu_addr,
  output logic flash_sel,
  output flash_cfg_pkg::flash_rd_req_type flash_rd_req,
  input wire flash_cfg_pkg::flash_rd_rsp_type flash_rd_rsp,
  output logic load_done,
  output logic [31:0] prot_pd,
  output logic [31:0] prot_pe,
  output logic [31:0] prot_su,
  output logic [31:0] security
);
  flash_cfg_pkg::state_type st_q;
  flash_cfg_pkg::state_type st_d;
  logic setup;
  logic wr;
  logic [7:0] ofs;
  logic upper_zero;
  logic mapped;
  logic [31:0] rd_val;
  logic prot_ofs;

  assign ofs = paddr[flash_cfg_pkg::DEC_HI:0];
  assign upper_zero = (paddr[31:flash_cfg_pkg::DEC_HI+1] == 24'h00_0000);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign prot_ofs = (ofs == flash_cfg_pkg::OFS_PROT_PD) || (ofs == flash_cfg_pkg::OFS_PROT_PE) ||
                    (ofs == flash_cfg_pkg::OFS_PROT_SU);

  always_comb begin
    mapped = upper_zero;
    rd_val = flash_cfg_pkg::REG_RESET;
    unique case (ofs)
      flash_cfg_pkg::OFS_BASE: begin
        rd_val[31:flash_cfg_pkg::BASE_LSB] = st_q.base;
        rd_val[flash_cfg_pkg::BASE_VALID_BIT] = st_q.base_valid;
      end
      flash_cfg_pkg::OFS_CFG: rd_val[flash_cfg_pkg::CFG_LOCK_BIT] = st_q.lock;
      flash_cfg_pkg::OFS_PROT_PD: rd_val = st_q.prot_pd;
      flash_cfg_pkg::OFS_PROT_PE: rd_val = st_q.prot_pe;
      flash_cfg_pkg::OFS_PROT_SU: rd_val = st_q.prot_su;
      flash_cfg_pkg::OFS_KEY_HI: rd_val = st_q.key_hi;
      flash_cfg_pkg::OFS_KEY_LO: rd_val = st_q.key_lo;
      flash_cfg_pkg::OFS_SECURITY: rd_val = st_q.security;
      flash_cfg_pkg::OFS_STATUS: begin
        rd_val[flash_cfg_pkg::STATUS_DONE_BIT] = (st_q.ld == flash_cfg_pkg::LD_DONE);
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Read data and error are latched in the setup phase so the bus sees flops
    if (setup) begin
      st_d.prdata = mapped ? rd_val : flash_cfg_pkg::REG_RESET;
      st_d.pslverr = !mapped;
    end
    // Software writes; the loader below overrides them in the same cycle
    if (wr && upper_zero) begin
      if (ofs == flash_cfg_pkg::OFS_BASE) begin
        st_d.base = pwdata[31:flash_cfg_pkg::BASE_LSB];
        st_d.base_valid = pwdata[flash_cfg_pkg::BASE_VALID_BIT];
      end
      if (ofs == flash_cfg_pkg::OFS_CFG) begin
        st_d.lock = pwdata[flash_cfg_pkg::CFG_LOCK_BIT];
      end
      // Locked writes are dropped silently, not flagged
      if (!st_q.lock) begin
        if (ofs == flash_cfg_pkg::OFS_PROT_PD) st_d.prot_pd = pwdata;
        if (ofs == flash_cfg_pkg::OFS_PROT_PE) st_d.prot_pe = pwdata;
        if (ofs == flash_cfg_pkg::OFS_PROT_SU) st_d.prot_su = pwdata;
      end
    end
    unique case (st_q.ld)
      flash_cfg_pkg::LD_STRAP: begin
        // Strap is sampled on the first edge after reset release, never by the reset itself
        st_d.boot = boot_from_flash;
        if (boot_from_flash) begin
          st_d.base = flash_cfg_pkg::BASE_BOOT;
          st_d.base_valid = 1'b1;
        end
        st_d.idx = 3'h0;
        st_d.ld = flash_cfg_pkg::LD_REQ;
      end
      flash_cfg_pkg::LD_REQ: st_d.ld = flash_cfg_pkg::LD_WAIT;
      flash_cfg_pkg::LD_WAIT: begin
        if (flash_rd_rsp.valid) begin
          unique case (st_q.idx)
            flash_cfg_pkg::IDX_KEY_HI: st_d.key_hi = flash_rd_rsp.data;
            flash_cfg_pkg::IDX_KEY_LO: st_d.key_lo = flash_rd_rsp.data;
            flash_cfg_pkg::IDX_PROT_PD: st_d.prot_pd = flash_rd_rsp.data;
            flash_cfg_pkg::IDX_PROT_PE: st_d.prot_pe = flash_rd_rsp.data;
            flash_cfg_pkg::IDX_PROT_SU: st_d.prot_su = flash_rd_rsp.data;
            default: st_d.security = flash_rd_rsp.data;
          endcase
          st_d.idx = st_q.idx + 3'h1;
          st_d.ld = (st_q.idx == flash_cfg_pkg::CFG_WORDS - 3'h1) ? flash_cfg_pkg::LD_DONE :
                    flash_cfg_pkg::LD_REQ;
        end
      end
      flash_cfg_pkg::LD_DONE: st_d.ld = flash_cfg_pkg::LD_DONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Byte address of the config item being fetched
  assign flash_rd_req.valid = (st_q.ld == flash_cfg_pkg::LD_REQ);
  assign flash_rd_req.addr = flash_cfg_pkg::CFG_START +
      {14'h0000, st_q.idx, 2'h0};
  // Flash array decode needs a programmed, valid base; 512-Kbyte aligned window
  assign flash_sel = st_q.base_valid &&
      (cpu_addr[31:flash_cfg_pkg::BASE_LSB] == st_q.base);
  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr;
  assign pready = 1'b1;
  assign load_done = (st_q.ld == flash_cfg_pkg::LD_DONE);
  assign prot_pd = st_q.prot_pd;
  assign prot_pe = st_q.prot_pe;
  assign prot_su = st_q.prot_su;
  assign security = st_q.security;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BOOT_BASE: assert property (
    (st_q.ld == flash_cfg_pkg::LD_STRAP && boot_from_flash) |=>
      (st_q.base == flash_cfg_pkg::BASE_BOOT && st_q.base_valid))
    else $error("boot from flash did not zero the base register");
  AST_RD_ADDR: assert property (
    flash_rd_req.valid |-> (flash_rd_req.addr >= 19'h00400 && flash_rd_req.addr <= 19'h00414 &&
      flash_rd_req.addr[1:0] == 2'h0))
    else $error("config fetch outside the 24-byte block");
  AST_LOAD_PE: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT && flash_rd_rsp.valid && st_q.idx == 3'h3) |=>
      (prot_pe == $past(flash_rd_rsp.data)))
    else $error("program/erase protection not copied from flash");
  AST_SIX_WORDS: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT && flash_rd_rsp.valid && st_q.idx == 3'h5) |=>
      (load_done && security == $past(flash_rd_rsp.data)))
    else $error("loader did not finish after the security word");
  AST_REQ_WAIT: assert property (
    flash_rd_req.valid |=> (st_q.ld == flash_cfg_pkg::LD_WAIT) && !flash_rd_req.valid)
    else $error("fetch request not followed by wait");
  AST_LOCK_HOLD: assert property (
    (wr && st_q.lock && upper_zero && prot_ofs && st_q.ld == flash_cfg_pkg::LD_DONE) |=>
      ($stable(prot_pd) && $stable(prot_pe) && $stable(prot_su)))
    else $error("locked write changed a protection register");
  AST_UNLOCK_WR: assert property (
    (wr && !st_q.lock && paddr == 32'h0000_000C && st_q.ld == flash_cfg_pkg::LD_DONE) |=>
      (prot_pe == $past(pwdata)))
    else $error("unlocked write to protection register lost");
  AST_NO_ERR: assert property (
    (psel && penable && upper_zero && prot_ofs) |-> !pslverr)
    else $error("protection register access flagged an error");
  // Without the boot strap the array stays unmapped until software programs the base
  AST_SEL_VALID: assert property (
    (st_q.ld == flash_cfg_pkg::LD_STRAP && !boot_from_flash && !wr) |=> !flash_sel)
    else $error("flash selected before software programmed the base");
  // The strap edge is left out: the boot path may overwrite the base there
  AST_BASE_WR: assert property (
    (wr && upper_zero && ofs == flash_cfg_pkg::OFS_BASE &&
      st_q.ld != flash_cfg_pkg::LD_STRAP) |=>
      (st_q.base == $past(pwdata[31:flash_cfg_pkg::BASE_LSB]) &&
       st_q.base_valid == $past(pwdata[flash_cfg_pkg::BASE_VALID_BIT])))
    else $error("software write to the base register lost");
  AST_STRAP_HELD: assert property (
    (st_q.ld == flash_cfg_pkg::LD_STRAP) |=> (st_q.boot == $past(boot_from_flash)))
    else $error("boot strap not captured after reset");
  AST_IDX_RANGE: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT) |-> (st_q.idx < flash_cfg_pkg::CFG_WORDS))
    else $error("config fetch index past the end of the block");
  AST_DONE_STAYS: assert property (
    load_done |=> (load_done && !flash_rd_req.valid))
    else $error("loader restarted without a reset");
  AST_LOAD_KEY: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT && flash_rd_rsp.valid &&
      st_q.idx == flash_cfg_pkg::IDX_KEY_LO) |=> (st_q.key_lo == $past(flash_rd_rsp.data)))
    else $error("back-door key word not copied from flash");
  AST_KEY_RO: assert property (
    (wr && upper_zero && ofs == flash_cfg_pkg::OFS_KEY_HI && st_q.ld == flash_cfg_pkg::LD_DONE)
      |=> $stable(st_q.key_hi))
    else $error("software write changed the loaded key");
  AST_LOAD_PD: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT && flash_rd_rsp.valid &&
      st_q.idx == flash_cfg_pkg::IDX_PROT_PD) |=> (prot_pd == $past(flash_rd_rsp.data)))
    else $error("program/data protection not copied from flash");
  AST_LOAD_SU: assert property (
    (st_q.ld == flash_cfg_pkg::LD_WAIT && flash_rd_rsp.valid &&
      st_q.idx == flash_cfg_pkg::IDX_PROT_SU) |=> (prot_su == $past(flash_rd_rsp.data)))
    else $error("supervisor/user protection not copied from flash");
  AST_PROT_READ: assert property (
    (setup && upper_zero && ofs == flash_cfg_pkg::OFS_PROT_PE) |=> (prdata == $past(prot_pe)))
    else $error("protection register read returned wrong contents");
endmodule

/* File: bench/flash_array_model.sv */
// Flash array model that answers config word reads promptly or slowly
`timescale 1ns/1ns
module flash_array_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [31:0] salt,
  input wire flash_cfg_pkg::flash_rd_req_type req,
  output flash_cfg_pkg::flash_rd_rsp_type rsp
);
  logic pend;
  logic [2:0] cnt;
  logic [18:0] a;
  logic fire;
  // A word is handed over once the countdown for the pending fetch has run out
  assign fire = pend && cnt == 3'h0 && !req.valid;
  // Idle data flips every cycle so a stale word never passes for a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'h0;
      cnt <= 3'h0;
      rsp <= {1'h0, 32'hA5A5_0F0F};
    end else begin
      rsp.valid <= fire;
      rsp.data <= fire ? salt + {13'h0, a} : ~rsp.data;
      if (req.valid) begin
        pend <= 1'h1;
        a <= req.addr;
        cnt <= slow ? 3'h4 : 3'h0;
      end else if (pend && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (pend) begin
        pend <= 1'h0;
      end
    end
  end
endmodule

/* File: bench/flash_protection_config_loader_tb.sv */
// Testbench for the flash protection config loader
`timescale 1ns/1ns
`define CHK(nm, exp_v, got_v) begin num_checks++; if ((exp_v) !== (got_v)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp_v, got_v); end end
module flash_protection_config_loader_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, boot_from_flash = 1, slow = 0;
  logic [31:0] paddr = 0, pwdata = 0, cpu_addr = 0, salt = 0, v;
  logic [31:0] prdata, prot_pd, prot_pe, prot_su, security;
  logic pready, pslverr, flash_sel, load_done;
  flash_cfg_pkg::flash_rd_req_type flash_rd_req;
  flash_cfg_pkg::flash_rd_rsp_type flash_rd_rsp;
  logic [32:0] notes[$];
  logic [32:0] e;
  int n_fail = 0, num_checks = 0;
  // Register offsets in flash word order
  logic [7:0] ofs[6] = '{8'h14, 8'h18, 8'h08, 8'h0C, 8'h10, 8'h1C};
  always #50 pclk = ~pclk;
  flash_protection_config_loader uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_from_flash(boot_from_flash),
    .cpu_addr(cpu_addr), .flash_sel(flash_sel), .flash_rd_req(flash_rd_req),
    .flash_rd_rsp(flash_rd_rsp), .load_done(load_done), .prot_pd(prot_pd),
    .prot_pe(prot_pe), .prot_su(prot_su), .security(security));
  flash_array_model flash (.pclk(pclk), .presetn(presetn), .slow(slow), .salt(salt),
    .req(flash_rd_req), .rsp(flash_rd_rsp));
  // Writes are judged on the error flag only
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e = notes.pop_front();
      `CHK("apb answer", e, {pslverr, pwrite ? e[31:0] : prdata})
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, d, input logic [32:0] x);
    int n = 0;
    notes.push_back(x);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic boot_run(input logic bf, input logic sl);
    int n = 0;
    presetn <= 1'h0;
    boot_from_flash <= bf;
    slow <= sl;
    salt <= $urandom;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    while (load_done !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic check_loaded();
    for (int i = 0; i < 6; i++)
      apb(1'h0, {24'h0, ofs[i]}, 32'h0, {1'h0, salt + 32'h400 + 32'(4 * i)});
    `CHK("prot_pd port", prot_pd, salt + 32'h408)
    `CHK("prot_pe port", prot_pe, salt + 32'h40C)
    `CHK("prot_su port", prot_su, salt + 32'h410)
    `CHK("security port", security, salt + 32'h414)
    apb(1'h0, 32'h20, 32'h0, {1'h0, 32'h1});
  endtask
  initial begin
    v = $urandom(25);
    boot_run(1'h1, 1'h0);
    check_loaded();
    apb(1'h0, 32'h00, 32'h0, {1'h0, 32'h0000_0001});
    v = $urandom;
    apb(1'h1, 32'h08, v, {1'h0, v});
    apb(1'h0, 32'h08, 32'h0, {1'h0, v});
    apb(1'h1, 32'h04, 32'h1, {1'h0, 32'h0});
    apb(1'h1, 32'h0C, ~v, {1'h0, ~v});
    apb(1'h0, 32'h0C, 32'h0, {1'h0, salt + 32'h40C});
    apb(1'h0, 32'h04, 32'h0, {1'h0, 32'h1});
    apb(1'h1, 32'h04, 32'h0, {1'h0, 32'h0});
    apb(1'h1, 32'h0C, ~v, {1'h0, ~v});
    apb(1'h0, 32'h24, 32'h0, {1'h1, 32'h0});
    // Upper address bits set: the write must not reach the protection register
    apb(1'h1, 32'h10C, v, {1'h1, v});
    apb(1'h0, 32'h0C, 32'h0, {1'h0, ~v});
    apb(1'h1, 32'h14, v, {1'h0, v});
    apb(1'h0, 32'h14, 32'h0, {1'h0, salt + 32'h400});
    apb(1'h1, 32'h04, 32'h1, {1'h0, 32'h0});
    // Second reset in mid-run: slow flash, no boot strap, lock set before
    boot_run(1'h0, 1'h1);
    check_loaded();
    apb(1'h0, 32'h04, 32'h0, {1'h0, 32'h0});
    apb(1'h0, 32'h00, 32'h0, {1'h0, 32'h0});
    cpu_addr <= 32'h0008_1234;
    @(posedge pclk);
    `CHK("select before base", flash_sel, 1'h0)
    apb(1'h1, 32'h00, 32'h0008_0001, {1'h0, 32'h0});
    `CHK("select at base", flash_sel, 1'h1)
    cpu_addr <= 32'h0010_1234;
    @(posedge pclk);
    `CHK("select off base", flash_sel, 1'h0)
    wrap_up();
  end
endmodule
